// [logic/mcv_pkg.sv]
// Constants for the system control register block: offsets, bit
// positions, reset value and sequence timing.
// Assumes the core addresses the register with 16-bit data-space
// addresses and 6-bit I/O addresses.
package mcv_pkg;

	// ---------------------------------------------------------------
	// Register placement
	// ---------------------------------------------------------------
	localparam logic [15:0] MCV_CTRL_DS_OFS = 16'h0055;
	localparam logic [15:0] MCV_IO_BASE     = 16'h0020;
	localparam logic [5:0]  MCV_CTRL_IO_OFS = 6'((MCV_CTRL_DS_OFS - MCV_IO_BASE));
	localparam logic [7:0]  MCV_CTRL_RESET  = 8'h00;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int MCV_B_UNLOCK   = 0;
	localparam int MCV_B_VSEL     = 1;
	localparam int MCV_B_PUOFF    = 4;
	localparam int MCV_B_BOUNLOCK = 5;
	localparam int MCV_B_BOOFF    = 6;

	// Implemented bits; the rest read zero and ignore writes.
	localparam logic [7:0]  MCV_CTRL_MASK   = 8'h73;

	// ---------------------------------------------------------------
	// Sequence timing, in clock cycles
	// ---------------------------------------------------------------
	localparam int MCV_VEC_WINDOW_CYC = 4;
	localparam int MCV_BO_WINDOW_CYC  = 4;
	localparam int MCV_BO_ACTIVE_CYC  = 3;

	// ---------------------------------------------------------------
	// Vector layout, in program words
	// ---------------------------------------------------------------
	localparam logic [15:0] MCV_VEC_FIRST_OFS = 16'h0002;
	localparam logic [15:0] MCV_APP_BASE      = 16'h0000;
	localparam int          MCV_BOOT_SIZE_FUSES_STEPS  = 3;

endpackage : mcv_pkg

// [logic/mcv_ctrl.sv]
// System control register: vector table placement with an unlock
// sequence, brown-out off in sleep with an unlock sequence, and a
// global pull-up disable.
// Assumes the core, fuses and lock bits are all on CLK.
//
// What this block does
// - Select bit zero bases vectors at flash start, one at boot section.
// - Boot section start comes from the boot size fuses only.
// - Select changes only within four cycles after writing the unlock bit.
// - Interrupts blocked from unlock until the instruction after select write ends.
// - Without a select write, interrupts stay blocked four cycles then release.
// - The blocking never touches the status register interrupt enable.
// - Unlock bit self-clears after four cycles or on the select write.
// - Boot vectors with application lock: no interrupts in application code.
// - Application vectors with boot lock: no interrupts in boot code.
// - Brown-out sleep-off set only by two writes at most four cycles apart.
// - Brown-out sleep-off is in force for three cycles after it is set.
// - Detector turns off only for sleep executed while sleep-off is active.
// - Brown-out sleep-off self-clears three cycles after being set.
// - Pull-up disable bit switches off every port pull-up.
// - Register at data offset 0x55, reset 0x00, fields at bits 6,5,4,1,0.
// - Reached at data offset 0x55 and I/O address 0x35.
// - Relocated first vector lies two words above the boot section start.
`timescale 1ns/1ns

module mcv_ctrl
	import mcv_pkg::*;
#(
	parameter int FLASH_WORDS    = 8192,
	parameter int BOOT_MIN_WORDS = 128
)
(
	input  wire logic        CLK,
	input  wire logic        RST_B,
	input  wire logic [15:0] DS_ADDR,
	input  wire logic        DS_WE,
	input  wire logic        DS_RE,
	input  wire logic [5:0]  IO_ADDR,
	input  wire logic        IO_WE,
	input  wire logic        IO_RE,
	input  wire logic [7:0]  WDATA,
	output logic      [7:0]  RDATA,
	output logic             RVALID,
	input  wire logic [1:0]  BOOT_SIZE_FUSES,
	input  wire logic        BOOT_RESET_FUSE_B,
	input  wire logic        APP_SECTION_LOCK,
	input  wire logic        BOOT_SECTION_LOCK,
	input  wire logic        PC_IN_BOOT,
	input  wire logic        INSTR_DONE,
	input  wire logic        SLEEP_EXEC,
	output logic      [15:0] VECTOR_BASE,
	output logic      [15:0] RESET_ADDR,
	output logic             IRQ_BLOCK,
	output logic             BROWNOUT_OFF,
	output logic             PULLUP_GLOBAL_OFF
);

	// ---------------------------------------------------------------
	// Parameter checks
	// ---------------------------------------------------------------
	if (BOOT_MIN_WORDS < 1 || FLASH_WORDS > 65536 ||
	    FLASH_WORDS < (BOOT_MIN_WORDS << MCV_BOOT_SIZE_FUSES_STEPS))
	begin : g_bad_size
		$error("Flash size cannot hold the largest boot section.");
	end

	// ---------------------------------------------------------------
	// Register state
	// ---------------------------------------------------------------
	logic       vector_change_unlock;
	logic       vector_table_select;
	logic       pullup_global_off;
	logic       brownout_sleep_off_unlock;
	logic       brownout_sleep_off;
	logic [2:0] vec_win_cnt;
	logic [2:0] bo_win_cnt;
	logic [1:0] bo_act_cnt;
	logic       vec_hold;
	logic       ctrl_wr;
	logic       ctrl_rd;
	logic       wr_unlock;
	logic       wr_select;
	logic       wr_bo_unlock;
	logic       wr_bo_set;
	logic       lock_block;
	logic [7:0] ctrl_image;
	logic [15:0] boot_words;
	logic [15:0] boot_base;

	// Both address spaces decode to the same single register.
	assign ctrl_wr = (DS_WE && DS_ADDR == MCV_CTRL_DS_OFS) ||
	                 (IO_WE && IO_ADDR == MCV_CTRL_IO_OFS);
	assign ctrl_rd = (DS_RE && DS_ADDR == MCV_CTRL_DS_OFS) ||
	                 (IO_RE && IO_ADDR == MCV_CTRL_IO_OFS);

	// Write classes for the two timed sequences.
	assign wr_unlock    = ctrl_wr && WDATA[MCV_B_UNLOCK];
	assign wr_select    = ctrl_wr && !WDATA[MCV_B_UNLOCK] && vector_change_unlock;
	assign wr_bo_unlock = ctrl_wr && WDATA[MCV_B_BOOFF] && WDATA[MCV_B_BOUNLOCK];
	assign wr_bo_set    = ctrl_wr && WDATA[MCV_B_BOOFF] && !WDATA[MCV_B_BOUNLOCK]
	                      && brownout_sleep_off_unlock;

	// ---------------------------------------------------------------
	// Vector table relocation
	// ---------------------------------------------------------------

	// Unlock bit and its window; a fresh unlock write restarts it.
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			vector_change_unlock <= 1'b0;
			vec_win_cnt          <= 3'h0;
		end
		else if (wr_unlock)
		begin
			vector_change_unlock <= 1'b1;
			vec_win_cnt          <= 3'(MCV_VEC_WINDOW_CYC);
		end
		else if (wr_select)
		begin
			vector_change_unlock <= 1'b0;
			vec_win_cnt          <= 3'h0;
		end
		else if (vec_win_cnt != 3'h0)
		begin
			vec_win_cnt <= vec_win_cnt - 3'h1;
			if (vec_win_cnt == 3'h1)
			begin
				vector_change_unlock <= 1'b0;
			end
		end
	end

	// Select only moves inside the window, so a stray write cannot
	// swing the vector table under running interrupts.
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			vector_table_select <= 1'b0;
		end
		else if (wr_select)
		begin
			vector_table_select <= WDATA[MCV_B_VSEL];
		end
	end

	// Hold after the select write until the next instruction ends;
	// the write instruction's own completion does not count.
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			vec_hold <= 1'b0;
		end
		else if (wr_select)
		begin
			vec_hold <= 1'b1;
		end
		else if (INSTR_DONE)
		begin
			vec_hold <= 1'b0;
		end
	end

	// Boot section size halves per fuse step; all-zero fuses give the
	// largest section.
	assign boot_words = 16'(BOOT_MIN_WORDS << (2'(MCV_BOOT_SIZE_FUSES_STEPS) - BOOT_SIZE_FUSES));
	assign boot_base  = 16'(FLASH_WORDS) - boot_words;

	// Section locks: interrupts vanish in the section the table is not in.
	assign lock_block = (vector_table_select && APP_SECTION_LOCK && !PC_IN_BOOT) ||
	                    (!vector_table_select && BOOT_SECTION_LOCK && PC_IN_BOOT);

	// The block is a separate gate; the core's global enable is left alone.
	assign IRQ_BLOCK = vector_change_unlock || vec_hold || lock_block;

	// Vector and reset bases follow the select bit and reset fuse.
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			VECTOR_BASE <= 16'(MCV_APP_BASE + MCV_VEC_FIRST_OFS);
			RESET_ADDR  <= MCV_APP_BASE;
		end
		else
		begin
			VECTOR_BASE <= 16'((vector_table_select ? boot_base : MCV_APP_BASE)
			               + MCV_VEC_FIRST_OFS);
			RESET_ADDR  <= BOOT_RESET_FUSE_B ? MCV_APP_BASE : boot_base;
		end
	end

	// ---------------------------------------------------------------
	// Brown-out off in sleep
	// ---------------------------------------------------------------

	// Unlock bit for the sleep-off bit, with its own four-cycle window.
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			brownout_sleep_off_unlock <= 1'b0;
			bo_win_cnt                <= 3'h0;
		end
		else if (wr_bo_unlock)
		begin
			brownout_sleep_off_unlock <= 1'b1;
			bo_win_cnt                <= 3'(MCV_BO_WINDOW_CYC);
		end
		else if (wr_bo_set)
		begin
			brownout_sleep_off_unlock <= 1'b0;
			bo_win_cnt                <= 3'h0;
		end
		else if (bo_win_cnt != 3'h0)
		begin
			bo_win_cnt <= bo_win_cnt - 3'h1;
			if (bo_win_cnt == 3'h1)
			begin
				brownout_sleep_off_unlock <= 1'b0;
			end
		end
	end

	// Sleep-off bit lives three cycles; a late sleep keeps the detector on.
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			brownout_sleep_off <= 1'b0;
			bo_act_cnt         <= 2'h0;
		end
		else if (wr_bo_set)
		begin
			brownout_sleep_off <= 1'b1;
			bo_act_cnt         <= 2'(MCV_BO_ACTIVE_CYC);
		end
		else if (bo_act_cnt != 2'h0)
		begin
			bo_act_cnt <= bo_act_cnt - 2'h1;
			if (bo_act_cnt == 2'h1)
			begin
				brownout_sleep_off <= 1'b0;
			end
		end
	end

	// Detector off only while sleep is executing and the bit is set.
	assign BROWNOUT_OFF = SLEEP_EXEC && brownout_sleep_off;

	// ---------------------------------------------------------------
	// Pull-up disable and read-back
	// ---------------------------------------------------------------

	// Plain read/write bit; overrides any per-pin pull-up setting.
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			pullup_global_off <= MCV_CTRL_RESET[MCV_B_PUOFF];
		end
		else if (ctrl_wr)
		begin
			pullup_global_off <= WDATA[MCV_B_PUOFF];
		end
	end

	assign PULLUP_GLOBAL_OFF = pullup_global_off;

	// Read image, masked so unused bits always read zero.
	always_comb
	begin
		ctrl_image                 = 8'h00;
		ctrl_image[MCV_B_UNLOCK]   = vector_change_unlock;
		ctrl_image[MCV_B_VSEL]     = vector_table_select;
		ctrl_image[MCV_B_PUOFF]    = pullup_global_off;
		ctrl_image[MCV_B_BOUNLOCK] = brownout_sleep_off_unlock;
		ctrl_image[MCV_B_BOOFF]    = brownout_sleep_off;
		ctrl_image                 = ctrl_image & MCV_CTRL_MASK;
	end

	// Read data is registered and answers one cycle after the strobe.
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			RDATA  <= MCV_CTRL_RESET;
			RVALID <= 1'b0;
		end
		else
		begin
			RVALID <= ctrl_rd;
			if (ctrl_rd)
			begin
				RDATA <= ctrl_image;
			end
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);

	property p_unlock_four;
		wr_unlock ##1 (!ctrl_wr)[*4] |=> !vector_change_unlock;
	endproperty
	a_unlock_four: assert property (p_unlock_four) else $error("Unlock bit outlived its window.");

	property p_unlock_block;
		wr_unlock |=> IRQ_BLOCK [*4];
	endproperty
	a_unlock_block: assert property (p_unlock_block) else $error("Interrupts not held during unlock.");

	property p_release_five;
		wr_unlock ##1 (!ctrl_wr && !lock_block)[*5] |-> !IRQ_BLOCK;
	endproperty
	a_release_five: assert property (p_release_five) else $error("Block not released after window.");

	property p_select_only_window;
		!vector_change_unlock |=> $stable(vector_table_select);
	endproperty
	a_select_only_window: assert property (p_select_only_window) else $error("Select moved outside window.");

	property p_hold_after_select;
		wr_select || (vec_hold && !INSTR_DONE) |=> IRQ_BLOCK;
	endproperty
	a_hold_after_select: assert property (p_hold_after_select) else $error("Block dropped early.");

	property p_base_follows;
		vector_table_select ##1 vector_table_select |->
			VECTOR_BASE == $past(boot_base) + MCV_VEC_FIRST_OFS;
	endproperty
	a_base_follows: assert property (p_base_follows) else $error("Vector base not in boot section.");

	property p_bo_life;
		wr_bo_set |=> brownout_sleep_off [*3] ##1 !brownout_sleep_off;
	endproperty
	a_bo_life: assert property (p_bo_life) else $error("Sleep-off bit life not three cycles.");

	property p_bo_guard;
		!brownout_sleep_off_unlock && !brownout_sleep_off |=> !brownout_sleep_off;
	endproperty
	a_bo_guard: assert property (p_bo_guard) else $error("Sleep-off set without unlock.");

	property p_bo_off_cause;
		BROWNOUT_OFF |-> SLEEP_EXEC && $past(brownout_sleep_off) || $past(wr_bo_set, 1);
	endproperty
	a_bo_off_cause: assert property (p_bo_off_cause) else $error("Detector off without armed bit.");

	property p_lock_app;
		vector_table_select && APP_SECTION_LOCK && !PC_IN_BOOT |-> IRQ_BLOCK;
	endproperty
	a_lock_app: assert property (p_lock_app) else $error("Application lock not honoured.");

	property p_lock_boot;
		!vector_table_select && BOOT_SECTION_LOCK && PC_IN_BOOT |-> IRQ_BLOCK;
	endproperty
	a_lock_boot: assert property (p_lock_boot) else $error("Boot lock not honoured.");

	property p_read_zero;
		RVALID |-> (RDATA & ~MCV_CTRL_MASK) == 8'h00;
	endproperty
	a_read_zero: assert property (p_read_zero) else $error("Unused bits read nonzero.");

endmodule : mcv_ctrl

// [sim/mcu_control_vector_bod_test.sv]
// Self-checking bench for the system control register block.
// Assumes mcv_ctrl and its package are compiled first; nothing else is needed.
`timescale 1ns/1ns

module mcu_control_vector_bod_test;

	// ---------------------------------------------------------------
	// Stimulus and observed signals
	// ---------------------------------------------------------------
	logic        CLK, RST_B, DS_WE, DS_RE, IO_WE, IO_RE, RVALID;
	logic        BOOT_RESET_FUSE_B, APP_SECTION_LOCK, BOOT_SECTION_LOCK;
	logic        PC_IN_BOOT, INSTR_DONE, SLEEP_EXEC, IRQ_BLOCK, BROWNOUT_OFF, PULLUP_GLOBAL_OFF;
	logic [15:0] DS_ADDR, VECTOR_BASE, RESET_ADDR, base;
	logic [5:0]  IO_ADDR;
	logic [7:0]  WDATA, RDATA;
	logic [1:0]  BOOT_SIZE_FUSES;
	int          mismatches, total_checks;

	mcv_ctrl i_dut
	(
		.CLK(CLK), .RST_B(RST_B), .DS_ADDR(DS_ADDR), .DS_WE(DS_WE), .DS_RE(DS_RE),
		.IO_ADDR(IO_ADDR), .IO_WE(IO_WE), .IO_RE(IO_RE), .WDATA(WDATA), .RDATA(RDATA),
		.RVALID(RVALID), .BOOT_SIZE_FUSES(BOOT_SIZE_FUSES), .BOOT_RESET_FUSE_B(BOOT_RESET_FUSE_B),
		.APP_SECTION_LOCK(APP_SECTION_LOCK), .BOOT_SECTION_LOCK(BOOT_SECTION_LOCK),
		.PC_IN_BOOT(PC_IN_BOOT), .INSTR_DONE(INSTR_DONE), .SLEEP_EXEC(SLEEP_EXEC),
		.VECTOR_BASE(VECTOR_BASE), .RESET_ADDR(RESET_ADDR), .IRQ_BLOCK(IRQ_BLOCK),
		.BROWNOUT_OFF(BROWNOUT_OFF), .PULLUP_GLOBAL_OFF(PULLUP_GLOBAL_OFF)
	);

	// The 100 MHz system clock.
	always #5 CLK = ~CLK;

	// ---------------------------------------------------------------
	// Access and comparison tasks
	// ---------------------------------------------------------------
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// Waits for edges, then steps past them so outputs have settled.
	task automatic tick(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask : tick

	// One write strobe, taken at the second edge; returns at that edge.
	task automatic wr(input bit io, input logic [7:0] d);
		@(posedge CLK);
		WDATA   <= d;
		DS_ADDR <= 16'h0055;
		IO_ADDR <= 6'h35;
		DS_WE   <= !io;
		IO_WE   <= io;
		@(posedge CLK);
		DS_WE <= 1'b0;
		IO_WE <= 1'b0;
	endtask : wr

	// A read that answers only at the register's own address.
	task automatic rd(input bit io, input logic [15:0] a, input logic [7:0] exp);
		@(posedge CLK);
		DS_ADDR <= a;
		IO_ADDR <= a[5:0];
		DS_RE   <= !io;
		IO_RE   <= io;
		@(posedge CLK);
		DS_RE <= 1'b0;
		IO_RE <= 1'b0;
		#1;
		chk("answer valid", RVALID, io ? a == 16'h0035 : a == 16'h0055);
		if (RVALID === 1'b1)
			chk("read data", RDATA, exp);
	endtask : rd

	task automatic done_pulse;
		@(posedge CLK);
		INSTR_DONE <= 1'b1;
		@(posedge CLK);
		INSTR_DONE <= 1'b0;
		tick(2);
	endtask : done_pulse

	task automatic end_of_test;
		$display("Checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test

	// Watchdog: the whole sequence needs well under 600 cycles.
	initial
	begin
		repeat (3000) @(posedge CLK);
		mismatches++;
		end_of_test();
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	// The status register enable is not visible here, so blocking is judged on IRQ_BLOCK alone.
	initial
	begin
		CLK = 1'b0;
		RST_B = 1'b0;
		{DS_WE, DS_RE, IO_WE, IO_RE, INSTR_DONE, SLEEP_EXEC} = '0;
		{APP_SECTION_LOCK, BOOT_SECTION_LOCK, PC_IN_BOOT, BOOT_SIZE_FUSES} = '0;
		BOOT_RESET_FUSE_B = 1'b1;
		DS_ADDR = 16'h0000;
		IO_ADDR = 6'h00;
		WDATA = 8'h00;
		mismatches = 0;
		total_checks = 0;
		repeat (16) @(posedge CLK);
		RST_B <= 1'b1;
		tick(1);
		rd(0, 16'h0055, 8'h00);
		chk("vector base", VECTOR_BASE, 16'h0002);
		chk("reset address", RESET_ADDR, 16'h0000);
		chk("irq block", IRQ_BLOCK, 1'b0);
		rd(0, 16'h0035, 8'h00);
		rd(1, 16'h0015, 8'h00);
		rd(1, 16'h0035, 8'h00);
		// Loose bits are dropped and a select write without unlock is ignored.
		wr(0, 8'h9e);
		tick(1);
		chk("pull-up off", PULLUP_GLOBAL_OFF, 1'b1);
		rd(1, 16'h0035, 8'h10);
		wr(1, 8'h00);
		tick(1);
		chk("pull-up off", PULLUP_GLOBAL_OFF, 1'b0);
		chk("vector base", VECTOR_BASE, 16'h0002);
		// Unlock alone blocks for four cycles; a later select write is too late.
		wr(1, 8'h01);
		#1;
		chk("irq block", IRQ_BLOCK, 1'b1);
		tick(3);
		chk("irq block", IRQ_BLOCK, 1'b1);
		tick(1);
		chk("irq block", IRQ_BLOCK, 1'b0);
		rd(0, 16'h0055, 8'h00);
		wr(1, 8'h02);
		tick(2);
		chk("vector base", VECTOR_BASE, 16'h0002);
		// Move to the boot section; the hold outlasts the window until an instruction ends.
		wr(0, 8'h01);
		wr(0, 8'h02);
		tick(3);
		chk("irq block", IRQ_BLOCK, 1'b1);
		chk("vector base", VECTOR_BASE, 16'h1c02);
		rd(0, 16'h0055, 8'h02);
		done_pulse();
		chk("irq block", IRQ_BLOCK, 1'b0);
		for (int f = 0; f < 4; f++)
		begin
			@(posedge CLK);
			BOOT_SIZE_FUSES   <= 2'(f);
			BOOT_RESET_FUSE_B <= 1'b0;
			tick(2);
			base = 16'(8192 - (128 << (3 - f)));
			chk("vector base", VECTOR_BASE, base + 16'h0002);
			chk("reset address", RESET_ADDR, base);
		end
		// Section locks, first with boot vectors, then with application vectors.
		@(posedge CLK);
		APP_SECTION_LOCK <= 1'b1;
		tick(1);
		chk("irq block", IRQ_BLOCK, 1'b1);
		@(posedge CLK);
		PC_IN_BOOT <= 1'b1;
		tick(1);
		chk("irq block", IRQ_BLOCK, 1'b0);
		wr(1, 8'h01);
		wr(1, 8'h00);
		done_pulse();
		chk("vector base", VECTOR_BASE, 16'h0002);
		chk("irq block", IRQ_BLOCK, 1'b0);
		@(posedge CLK);
		BOOT_SECTION_LOCK <= 1'b1;
		tick(1);
		chk("irq block", IRQ_BLOCK, 1'b1);
		@(posedge CLK);
		PC_IN_BOOT <= 1'b0;
		tick(1);
		chk("irq block", IRQ_BLOCK, 1'b0);
		// Brown-out sleep-off armed in time, held three cycles, then armed too late.
		wr(0, 8'h60);
		wr(0, 8'h40);
		SLEEP_EXEC <= 1'b1;
		#1;
		chk("brown-out off", BROWNOUT_OFF, 1'b1);
		tick(2);
		chk("brown-out off", BROWNOUT_OFF, 1'b1);
		tick(1);
		chk("brown-out off", BROWNOUT_OFF, 1'b0);
		wr(0, 8'h60);
		tick(5);
		chk("brown-out off", BROWNOUT_OFF, 1'b0);
		wr(0, 8'h40);
		tick(1);
		chk("brown-out off", BROWNOUT_OFF, 1'b0);
		@(posedge CLK);
		SLEEP_EXEC <= 1'b0;
		// A second reset in mid-run clears the register again.
		wr(0, 8'h10);
		@(posedge CLK);
		RST_B <= 1'b0;
		repeat (2) @(posedge CLK);
		RST_B <= 1'b1;
		tick(1);
		chk("pull-up off", PULLUP_GLOBAL_OFF, 1'b0);
		rd(1, 16'h0035, 8'h00);
		end_of_test();
	end

endmodule : mcu_control_vector_bod_test
